// ==== hdl/psm_ctrl.sv ====
// power saving mode control: top with apb registers and mode sequencer
// assumes cpu strobes are one-cycle pulses on sys_clk; irq inputs are synchronous
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "psm_cfg.svh"
module psm_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wait_for_irq_instruction,
  input  wire logic        halt_instruction,
  input  wire logic        irq_pending,
  input  wire logic        halt_wake_irq,
  input  wire logic        timebase_irq,
  input  wire logic        ext_reset_req,
  input  wire logic        watchdog_enabled,
  input  wire logic        watchdog_halt_option,
  input  wire logic        stab_long_option,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             osc_enable,
  output logic             timebase_clk_en,
  output logic             imask_force,
  output logic [1:0]       imask_value,
  output logic             cpu_wake,
  output logic             watchdog_reset,
  output logic             irq
);
  logic [3:0]                csr_q;
  logic [`PSM_EV_W-1:0]      sts_q;
  logic [`PSM_EV_W-1:0]      msk_q;
  logic [12:0]               dly_q;
  logic [12:0]               dly_d;
  psm_pkg::psm_state_t       st_q;
  psm_pkg::psm_state_t       st_d;
  logic                      slow_wait_q;
  psm_clk_if                 cif ();

  // apb decode
  wire        acc      = psel && penable;
  // writes and read side effects land only at the edge that completes the transfer
  wire        xfer     = acc && pready;
  wire        wr       = xfer && pwrite;
  wire        rd       = xfer && !pwrite;
  wire        rd_req   = acc && !pwrite && !pready;
  wire        hit_csr  = (paddr == `PSM_OFF_CLKCSR);
  wire        hit_sts  = (paddr == `PSM_OFF_STATUS);
  wire        hit_msk  = (paddr == `PSM_OFF_MASK);
  wire        hit_st   = (paddr == `PSM_OFF_STATE);
  wire        hit_any  = hit_csr || hit_sts || hit_msk || hit_st;
  wire [31:0] rd_mux   = hit_csr ? {28'h0000000, csr_q} :
                         hit_sts ? {28'h0000000, sts_q} :
                         hit_msk ? {28'h0000000, msk_q} :
                         hit_st  ? {28'h0000000, slow_wait_q, st_q} : `PSM_ZERO32;

  wire slow_en = csr_q[`PSM_CSR_SME];
  wire osc_irq_enable     = csr_q[`PSM_CSR_OIE];
  assign cif.slow_en  = slow_en;
  assign cif.prescale = csr_q[`PSM_CSR_SPS_HI:`PSM_CSR_SPS_LO];

  psm_clk_div u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cif     (cif)
  );

  // a reset request also counts as a wake source from every low power mode
  wire in_run   = (st_q == psm_pkg::PSM_RUN);
  wire go_wait  = in_run && wait_for_irq_instruction;
  wire go_halt  = in_run && halt_instruction && !wait_for_irq_instruction;
  wire wake_w   = irq_pending || ext_reset_req;
  wire wake_ah  = timebase_irq || halt_wake_irq || irq_pending || ext_reset_req;
  wire wake_h   = halt_wake_irq || irq_pending || ext_reset_req;
  wire dly_done = (dly_q == 13'h0000) && cif.tick;
  wire [12:0] dly_len = stab_long_option ? `PSM_DLY_LONG : `PSM_DLY_SHORT;
  // plain halt with watchdog running and option forbidding it resets the device
  wire wdg_trip = go_halt && !osc_irq_enable && watchdog_enabled && !watchdog_halt_option;

  always_comb begin
    st_d  = st_q;
    dly_d = dly_q;
    case (st_q)
      psm_pkg::PSM_RUN: begin
        if (go_wait) begin
          st_d = psm_pkg::PSM_WAIT;
        end else if (go_halt) begin
          st_d = osc_irq_enable ? psm_pkg::PSM_AHALT : psm_pkg::PSM_HALT;
        end
      end
      psm_pkg::PSM_WAIT: begin
        if (wake_w) begin
          st_d = psm_pkg::PSM_RUN;
        end
      end
      psm_pkg::PSM_AHALT: begin
        if (ext_reset_req) begin
          st_d  = psm_pkg::PSM_STAB;
          dly_d = dly_len - 13'h0001;
        end else if (wake_ah) begin
          st_d = psm_pkg::PSM_RUN;
        end
      end
      psm_pkg::PSM_HALT: begin
        if (wake_h) begin
          st_d  = psm_pkg::PSM_STAB;
          dly_d = dly_len - 13'h0001;
        end
      end
      psm_pkg::PSM_STAB: begin
        if (dly_done) begin
          st_d = psm_pkg::PSM_RUN;
        end else if (cif.tick) begin
          dly_d = dly_q - 13'h0001;
        end
      end
      default: begin
        st_d = psm_pkg::PSM_RUN;
      end
    endcase
  end

  wire ev_wake = (st_q != psm_pkg::PSM_RUN) && (st_d == psm_pkg::PSM_RUN);
  wire [`PSM_EV_W-1:0] ev_set;
  assign ev_set[`PSM_EV_WAIT] = go_wait;
  assign ev_set[`PSM_EV_HALT] = go_halt;
  assign ev_set[`PSM_EV_WAKE] = ev_wake;
  assign ev_set[`PSM_EV_WDG]  = wdg_trip;
  wire [`PSM_EV_W-1:0] sts_clr = (rd && hit_sts) ? {`PSM_EV_W{1'b1}} : {`PSM_EV_W{1'b0}};

  // registers: csr, mask, status (read clears, set wins)
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      csr_q <= `PSM_CSR_RST;
      msk_q <= 4'h0;
      sts_q <= 4'h0;
    end else begin
      if (wr && hit_csr) begin
        csr_q <= pwdata[3:0];
      end
      if (wr && hit_msk) begin
        msk_q <= pwdata[`PSM_EV_W-1:0];
      end
      sts_q <= (sts_q & ~sts_clr) | ev_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q        <= psm_pkg::PSM_RUN;
      dly_q       <= 13'h0000;
      slow_wait_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      dly_q       <= dly_d;
      // slow-wait: wait entered while already slow
      slow_wait_q <= (st_d == psm_pkg::PSM_WAIT) && (go_wait ? slow_en : slow_wait_q);
    end
  end

  // clock gates and cpu side outputs, all registered
  wire next_run  = (st_d == psm_pkg::PSM_RUN);
  wire next_wait = (st_d == psm_pkg::PSM_WAIT);
  wire next_ah   = (st_d == psm_pkg::PSM_AHALT);
  wire next_halt = (st_d == psm_pkg::PSM_HALT);
  wire div_tick  = cif.tick;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cpu_clk_en      <= 1'b1;
      periph_clk_en   <= 1'b1;
      osc_enable      <= 1'b1;
      timebase_clk_en <= 1'b1;
      imask_force     <= 1'b0;
      imask_value     <= 2'h0;
      cpu_wake        <= 1'b0;
      watchdog_reset  <= 1'b0;
      irq             <= 1'b0;
      prdata          <= `PSM_ZERO32;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
    end else begin
      // slow mode feeds both cpu and peripherals from divided clock
      cpu_clk_en      <= next_run && div_tick;
      periph_clk_en   <= (next_run || next_wait) && div_tick;
      osc_enable      <= !next_halt && (st_d != psm_pkg::PSM_STAB || st_q == psm_pkg::PSM_STAB
                         || !next_halt);
      // timebase runs from the oscillator, not from the divided cpu clock
      timebase_clk_en <= !next_halt;
      // mask forced to 10 while sleeping so pending interrupts wake wait and active halt at once, halt after stabilisation
      imask_force     <= next_wait || next_ah || next_halt;
      imask_value     <= `PSM_IMASK_ENTRY;
      // pulse tells core to push condition codes and vector; core handles the stack
      cpu_wake        <= ev_wake;
      watchdog_reset  <= wdg_trip;
      // mirrors the next status value so a set in the clearing cycle still raises irq
      irq             <= |(((sts_q & ~sts_clr) | ev_set) & msk_q);
      prdata          <= rd_req ? rd_mux : `PSM_ZERO32;
      pready          <= acc && !pready;
      pslverr         <= acc && !pready && !hit_any;
    end
  end
endmodule

// ==== hdl/psm_cfg.svh ====
// power saving mode control: constants for offsets, fields, resets, timing
// assumes inclusion by bare name from the design files that use its macros
`ifndef PSM_CFG_SVH
`define PSM_CFG_SVH
// register byte offsets
`define PSM_OFF_CLKCSR   12'h000
`define PSM_OFF_STATUS   12'h004
`define PSM_OFF_MASK     12'h008
`define PSM_OFF_STATE    12'h00c
// clock controller status register fields
`define PSM_CSR_SPS_LO   0
`define PSM_CSR_SPS_HI   1
`define PSM_CSR_SME      2
`define PSM_CSR_OIE      3
`define PSM_CSR_RST      4'h0
// event bits
`define PSM_EV_W         4
`define PSM_EV_WAIT      0
`define PSM_EV_HALT      1
`define PSM_EV_WAKE      2
`define PSM_EV_WDG       3
// condition code mask forced on entry: interrupts enabled
`define PSM_IMASK_ENTRY  2'h2
// stabilisation delays in cpu cycles
`define PSM_DLY_SHORT    13'h0100
`define PSM_DLY_LONG     13'h1000
`define PSM_DIV_W        4
`define PSM_ZERO32       32'h0000_0000
`endif

// ==== hdl/psm_pkg.sv ====
// power saving mode control: shared types
// assumes psm_cfg.svh supplies the numeric constants
package psm_pkg;
  typedef enum logic [2:0] {
    PSM_RUN      = 3'h0,
    PSM_WAIT     = 3'h1,
    PSM_AHALT    = 3'h2,
    PSM_HALT     = 3'h3,
    PSM_STAB     = 3'h4
  } psm_state_t;
endpackage

// ==== hdl/psm_clk_if.sv ====
// power saving mode control: divider request/answer bundle
// assumes one clock domain, sys_clk
`timescale 1ns/1ps
interface psm_clk_if;
  logic       slow_en;
  logic [1:0] prescale;
  logic       tick;
  modport ctl (output slow_en, output prescale, input tick);
  modport div (input slow_en, input prescale, output tick);
endinterface

// ==== hdl/psm_clk_div.sv ====
// power saving mode control: cpu clock enable divider
// assumes sys_clk is the master clock; tick marks one cpu cycle
`timescale 1ns/1ps
`include "psm_cfg.svh"
module psm_clk_div (
  input  wire logic sys_clk,
  input  wire logic rst,
  psm_clk_if.div    cif
);
  logic [`PSM_DIV_W-1:0] cnt_q;
  logic [`PSM_DIV_W-1:0] cnt_d;
  logic [`PSM_DIV_W-1:0] lim;
  logic                  wrap;
  // codes 00..11 give 2,4,8,16
  assign lim   = `PSM_DIV_W'(({`PSM_DIV_W{1'b0}} | 4'h2) << cif.prescale) - 4'h1;
  assign wrap  = (cnt_q >= lim);
  assign cnt_d = (!cif.slow_en || wrap) ? 4'h0 : cnt_q + 4'h1;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q    <= 4'h0;
      cif.tick <= 1'b1;
    end else begin
      cnt_q    <= cnt_d;
      cif.tick <= !cif.slow_en || wrap;
    end
  end
endmodule

// ==== sim/psm_ctrl_sva.sv ====
// checker for the power mode outputs of psm_ctrl
// assumes it is bound to psm_ctrl with one clock domain
`timescale 1ns/1ps
module psm_ctrl_sva (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       wait_for_irq_instruction,
  input wire logic       halt_instruction,
  input wire logic       irq_pending,
  input wire logic       watchdog_enabled,
  input wire logic       watchdog_halt_option,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       osc_enable,
  input wire logic       timebase_clk_en,
  input wire logic       imask_force,
  input wire logic [1:0] imask_value,
  input wire logic       cpu_wake,
  input wire logic       watchdog_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_reset_run: assert property ($fell(rst) |-> cpu_clk_en && osc_enable && !imask_force)
    else $error("not in run after reset");
  a_halt_all_off: assert property (!osc_enable |-> !cpu_clk_en && !periph_clk_en)
    else $error("clock running with oscillator off");
  a_timebase_osc: assert property (timebase_clk_en == osc_enable)
    else $error("timebase clock differs from oscillator");
  a_mask_value: assert property (imask_force |-> imask_value == 2'h2)
    else $error("forced mask value wrong");
  a_halt_mask: assert property (!osc_enable |-> imask_force)
    else $error("mask not forced in halt");
  a_wait_enter: assert property (wait_for_irq_instruction && !imask_force |=> imask_force && osc_enable)
    else $error("wait not entered");
  a_wait_wake: assert property (imask_force && periph_clk_en && irq_pending |=> cpu_wake)
    else $error("no wake from wait");
  a_halt_delay: assert property (!osc_enable |=> !cpu_wake [*8])
    else $error("halt woke without delay");
  a_wdg_cause: assert property (watchdog_reset |-> !osc_enable
    && $past(halt_instruction && watchdog_enabled && !watchdog_halt_option))
    else $error("watchdog reset without cause");
endmodule
bind psm_ctrl psm_ctrl_sva chk (.sys_clk, .rst, .wait_for_irq_instruction, .halt_instruction, .irq_pending,
  .watchdog_enabled, .watchdog_halt_option, .cpu_clk_en, .periph_clk_en, .osc_enable, .timebase_clk_en,
  .imask_force, .imask_value, .cpu_wake, .watchdog_reset);

// ==== sim/psm_core_model.sv ====
// cpu core and interrupt sources facing psm_ctrl
// assumes sys_clk is the only clock; strobes last one cycle
`timescale 1ns/1ps
module psm_core_model (
  input  wire logic sys_clk,
  input  wire logic cpu_wake,
  output logic      wait_for_irq_instruction,
  output logic      halt_instruction,
  output logic      irq_pending,
  output logic      halt_wake_irq,
  output logic      timebase_irq,
  output logic      ext_reset_req
);
  initial {wait_for_irq_instruction, halt_instruction} = 2'h0;
  initial {ext_reset_req, timebase_irq, halt_wake_irq, irq_pending} = 4'h0;
  task automatic pulse(input logic h);
    @(posedge sys_clk);
    if (h) halt_instruction <= 1'b1;
    else wait_for_irq_instruction <= 1'b1;
    @(posedge sys_clk);
    {wait_for_irq_instruction, halt_instruction} <= 2'h0;
  endtask
  task automatic src(input logic [3:0] v);
    @(posedge sys_clk);
    {ext_reset_req, timebase_irq, halt_wake_irq, irq_pending} <= v;
  endtask
  // vector fetch and stacking acknowledge the request lines
  always @(posedge sys_clk) if (cpu_wake) begin
    {ext_reset_req, timebase_irq, halt_wake_irq, irq_pending} <= 4'h0;
  end
endmodule

// ==== sim/test_power_saving_mode_control.sv ====
// self-checking bench for psm_ctrl power modes over apb
// assumes psm_core_model stands in for the cpu core and irq sources
`timescale 1ns/1ps
module test_power_saving_mode_control;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, err, irq;
  logic        watchdog_enabled, watchdog_halt_option, stab_long_option, cpu_wake, watchdog_reset;
  logic        cpu_clk_en, periph_clk_en, osc_enable, timebase_clk_en, imask_force;
  logic        wait_for_irq_instruction, halt_instruction, irq_pending, halt_wake_irq, timebase_irq, ext_reset_req;
  logic [1:0]  imask_value;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          failures, n_tests, n, m;
  psm_ctrl dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .wait_for_irq_instruction, .halt_instruction, .irq_pending, .halt_wake_irq, .timebase_irq, .ext_reset_req,
    .watchdog_enabled, .watchdog_halt_option, .stab_long_option, .cpu_clk_en, .periph_clk_en, .osc_enable,
    .timebase_clk_en, .imask_force, .imask_value, .cpu_wake, .watchdog_reset, .irq);
  psm_core_model core (.sys_clk, .cpu_wake, .wait_for_irq_instruction, .halt_instruction, .irq_pending,
    .halt_wake_irq, .timebase_irq, .ext_reset_req);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // pulse counts over a whole number of divider periods are phase free
  task automatic cnt;
    n = 0;
    m = 0;
    repeat (32) begin
      @(posedge sys_clk);
      n += cpu_clk_en;
      m += periph_clk_en;
    end
  endtask
  task automatic wake;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cpu_wake !== 1'b1 && n < 5000);
  endtask
  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 32'h1);
  endtask
  task automatic t_slow;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h000, 32'(4 + k));
      repeat (20) @(posedge sys_clk);
      cnt;
      chk(n, 32 >> (k + 1));
      chk(m, 32 >> (k + 1));
    end
  endtask
  task automatic t_slow_wait;
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h000, 32'h5);
    core.pulse(1'b0);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h9);
    cnt;
    chk(n, 0);
    chk(m, 8);
    chk(32'(imask_value), 32'h2);
    core.src(4'h1);
    wake;
    chk(irq, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h5);
    @(posedge sys_clk);
    chk(irq, 32'h0);
  endtask
  task automatic t_ahalt;
    apb(1'b1, 12'h000, 32'h8);
    {watchdog_enabled, watchdog_halt_option} <= 2'h2;
    core.pulse(1'b1);
    @(posedge sys_clk);
    chk(watchdog_reset, 32'h0);
    chk({osc_enable, periph_clk_en}, 32'h2);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h2);
    core.src(4'h4);
    wake;
    chk(n <= 3, 32'h1);
  endtask
  task automatic t_halt(input logic opt, input int d);
    apb(1'b1, 12'h000, 32'h0);
    {watchdog_halt_option, stab_long_option} <= {opt, !opt};
    core.pulse(1'b1);
    @(posedge sys_clk);
    chk({osc_enable, cpu_clk_en}, 32'h0);
    chk(watchdog_reset, 32'(!opt));
    core.src(opt ? 4'h2 : 4'h8);
    wake;
    chk(n >= d && n <= d + 8, 32'h1);
  endtask
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h0, 32'h0};
    {watchdog_enabled, watchdog_halt_option, stab_long_option} = 3'h0;
    {failures, n_tests} = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_slow;
    t_slow_wait;
    t_ahalt;
    t_halt(1'b1, 256);
    t_halt(1'b0, 4096);
    summarize;
  end
  initial begin
    #100000;
    failures++;
    summarize;
  end
endmodule
